// ### verilog/pin_router_pkg.sv
// package: constants and carriers for the multifunction pin router
// assumes a 32-bit avalon-mm slave and seven multifunction terminals
//
// Contract
// (R1) software programs routing once at power-up
// (R2) routing default loadable from serial eeprom
// (R3) bits 31-28 read zero, writes ignored
// (R4) selectors cleared only by global reset; the code's reset loads terminal 3's selector with 0001 instead of clearing it
// (R5) terminal 6 selector, code 0000 reserved
// (R6) terminal 5 lower codes select functions
// (R7) terminal 5 upper codes select functions
// (R8) terminal 4 lower codes select functions
// (R9) terminal 4 upper codes select functions
// (R10) terminal 3: serialized irq, irq2-irq15
// (R11) terminal 2 lower codes select functions
// (R12) terminal 2 upper codes select functions
// (R13) terminal 1: input 1, leds, event, irq15
// (R14) terminal 0: input 0, audio, irqs, leds
// (R15) input change sets event status flag
// (R16) general output drives output register bit
// (R17) reserved codes leave terminal idle
// (R18) inputs undriven, outputs driven continuously
package pin_router_pkg;
  // ==========================================================
  // bus map
  localparam int          ADDR_W          = 8;
  localparam int          NUM_PINS        = 7;
  localparam int          NUM_GP          = 5;
  localparam logic [7:0]  ROUTE_OFFSET    = 8'h8c;
  localparam logic [7:0]  GPIO_OFFSET     = 8'h88;
  localparam logic [31:0] ROUTE_RESET     = 32'h0000_1000;
  localparam logic [31:0] ROUTE_MASK      = 32'h0fff_ffff;
  localparam logic [4:0]  GP_RESET        = 5'h00;
  // gpio word field positions
  localparam int          STS_LSB         = 0;
  localparam int          EN_LSB          = 8;
  localparam int          IN_LSB          = 16;
  localparam int          OUT_LSB         = 24;
  // ==========================================================
  // selector codes
  localparam logic [3:0]  SEL_GPI         = 4'h0;
  localparam logic [3:0]  SEL_GPO         = 4'h1;
  localparam logic [3:0]  SEL_SERIRQ      = 4'h1;
  localparam logic [3:0]  SEL_PCI_LINE    = 4'h2;
  localparam logic [3:0]  SEL_IRQ3        = 4'h3;
  localparam logic [3:0]  SEL_IRQ4        = 4'h4;
  localparam logic [3:0]  SEL5_DBG_RX     = 4'h4;
  localparam logic [3:0]  SEL_IRQ5        = 4'h5;
  localparam logic [3:0]  SEL4_DBG_TX     = 4'h5;
  localparam logic [3:0]  SEL_AUDIO       = 4'h8;
  localparam logic [3:0]  SEL_IRQ9        = 4'h9;
  localparam logic [3:0]  SEL2_FLASH_LED  = 4'h9;
  localparam logic [3:0]  SEL_A           = 4'ha;
  localparam logic [3:0]  SEL_B           = 4'hb;
  localparam logic [3:0]  SEL_C           = 4'hc;
  localparam logic [3:0]  SEL_D           = 4'hd;
  localparam logic [3:0]  SEL_GPE         = 4'he;
  localparam logic [3:0]  SEL_IRQ15       = 4'hf;
  localparam logic [3:0]  IRQ7            = 4'h7;
  // ==========================================================
  // carriers
  typedef enum logic [2:0] {
    K_NONE  = 3'b000,
    K_OUT   = 3'b001,
    K_GPI   = 3'b010,
    K_GRANT = 3'b011,
    K_RX    = 3'b100
  } pin_kind_t;

  typedef struct packed {
    pin_kind_t  kind;
    logic       level;
  } pin_cfg_t;

  typedef struct packed {
    logic [15:0] irq;
    logic        serirq;
    logic        pci_req;
    logic        dbg_tx;
    logic        audio_pwm;
    logic        flash_media_led;
    logic        link_led;
    logic        led_a_one;
    logic        led_a_two;
    logic        skt_led;
    logic        ring_out;
    logic        intc;
    logic        intd;
    logic        internal_test_multiplexer;
  } src_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
  } pin_drive_t;
endpackage : pin_router_pkg

// ### verilog/pin_sync.sv
// two-flop synchroniser for the terminal input levels
// assumes asynchronous pin levels and a clock enable from the core
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // refuse an empty input bus
  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_sync needs a positive width");
  end

  // first stage feeds only the second
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = i_async;
    st_nxt.sync = st_r.meta;
  end

  // registered stages
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      st_r <= '0;
    else if (i_ce)
      st_r <= st_nxt;
  end

  assign o_sync = st_r.sync;
endmodule : pin_sync
`default_nettype wire

// ### verilog/multifunction_pin_router.sv
// multifunction pin router: routing register, gpio event logic, pin mux
// assumes avalon-mm master on i_core_clk, terminals asynchronous
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module multifunction_pin_router (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_ce,
  // avalon-mm slave
  input  wire logic [7:0]              i_address,
  input  wire logic                    i_read,
  input  wire logic                    i_write,
  input  wire logic [3:0]              i_byteenable,
  input  wire logic [31:0]             i_writedata,
  output logic      [31:0]             o_readdata,
  output logic                         o_waitrequest,
  // default routing from eeprom loader
  input  wire logic                    i_eeprom_load,
  input  wire logic [31:0]             i_eeprom_data,
  // internal function sources
  input  wire pin_router_pkg::src_t    i_src,
  // internal function sinks
  output logic                         o_pci_grant_line,
  output logic                         o_debug_serial_receive,
  output logic                         o_gpe_active,
  // terminals
  input  wire logic [6:0]              i_pin_in,
  output logic      [6:0]              o_pin_out,
  output logic      [6:0]              o_pin_oe
);
  localparam int NP = pin_router_pkg::NUM_PINS;
  localparam int NG = pin_router_pkg::NUM_GP;

  typedef struct packed {
    logic [31:0]              route;
    logic [NG-1:0]            gpo;
    logic [NG-1:0]            gpi;
    logic [NG-1:0]            sts;
    logic [NG-1:0]            en;
    logic                     ack;
    logic [31:0]              rdata;
    pin_router_pkg::pin_drive_t drv;
    logic                     grant;
    logic                     rx;
    logic                     general_purpose_event_out;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ==========================================================
  // input synchroniser
  logic [NP-1:0] pin_s;

  pin_sync #(
    .WIDTH (NP)
  ) i_pin_sync (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_ce       (i_ce),
    .i_async    (i_pin_in),
    .o_sync     (pin_s)
  );

  // ==========================================================
  // selector decode per terminal
  function automatic pin_router_pkg::pin_cfg_t decode(
    input int                   idx,
    input logic [3:0]           code,
    input pin_router_pkg::src_t s,
    input logic [NG-1:0]        gpo,
    input logic                 gpe_n
  );
    pin_router_pkg::pin_cfg_t c;
    c = '{kind: pin_router_pkg::K_NONE, level: 1'b0};
    // upper shared code, general event
    if (code == pin_router_pkg::SEL_GPE && idx != 3 && idx != 6)
      c = '{kind: pin_router_pkg::K_OUT, level: gpe_n};
    case (idx)
      5:
      begin
        case (code)
          pin_router_pkg::SEL_GPI:      c.kind = pin_router_pkg::K_GPI;
          pin_router_pkg::SEL_GPO:      c = '{pin_router_pkg::K_OUT, gpo[4]};
          pin_router_pkg::SEL_PCI_LINE: c.kind = pin_router_pkg::K_GRANT;
          pin_router_pkg::SEL5_DBG_RX:  c.kind = pin_router_pkg::K_RX;
          pin_router_pkg::SEL_AUDIO:    c = '{pin_router_pkg::K_OUT, s.audio_pwm};
          pin_router_pkg::SEL_A:        c = '{pin_router_pkg::K_OUT, s.flash_media_led};
          pin_router_pkg::SEL_B:        c = '{pin_router_pkg::K_OUT, s.link_led};
          pin_router_pkg::SEL_C:        c = '{pin_router_pkg::K_OUT, s.led_a_one};
          pin_router_pkg::SEL_D:        c = '{pin_router_pkg::K_OUT, s.skt_led};
          pin_router_pkg::SEL_IRQ3,
          pin_router_pkg::SEL_IRQ5,
          pin_router_pkg::SEL_IRQ9,
          pin_router_pkg::SEL_IRQ15:    c = '{pin_router_pkg::K_OUT, s.irq[code]};
          default:                      ; // [R6] [R7] [R17]
        endcase
      end
      4:
      begin
        case (code)
          pin_router_pkg::SEL_GPI:      c.kind = pin_router_pkg::K_GPI;
          pin_router_pkg::SEL_GPO:      c = '{pin_router_pkg::K_OUT, gpo[3]};
          pin_router_pkg::SEL4_DBG_TX:  c = '{pin_router_pkg::K_OUT, s.dbg_tx};
          pin_router_pkg::SEL_AUDIO:    c = '{pin_router_pkg::K_OUT, s.audio_pwm};
          pin_router_pkg::SEL_A:        c = '{pin_router_pkg::K_OUT, s.intd};
          pin_router_pkg::SEL_B:        c = '{pin_router_pkg::K_OUT, s.flash_media_led};
          pin_router_pkg::SEL_C:        c = '{pin_router_pkg::K_OUT, s.ring_out};
          pin_router_pkg::SEL_D:        c = '{pin_router_pkg::K_OUT, s.skt_led};
          pin_router_pkg::SEL_IRQ3,
          pin_router_pkg::SEL_IRQ4,
          pin_router_pkg::SEL_IRQ9,
          pin_router_pkg::SEL_IRQ15:    c = '{pin_router_pkg::K_OUT, s.irq[code]};
          default:                      ; // [R8] [R9] [R17]
        endcase
      end
      3:
      begin
        if (code == pin_router_pkg::SEL_SERIRQ)
          c = '{pin_router_pkg::K_OUT, s.serirq}; // [R10]
        else if (code >= pin_router_pkg::SEL_PCI_LINE)
          c = '{pin_router_pkg::K_OUT, s.irq[code]}; // [R10]
      end
      2:
      begin
        case (code)
          pin_router_pkg::SEL_GPI:      c.kind = pin_router_pkg::K_GPI;
          pin_router_pkg::SEL_GPO:      c = '{pin_router_pkg::K_OUT, gpo[2]};
          pin_router_pkg::SEL_PCI_LINE: c = '{pin_router_pkg::K_OUT, s.pci_req};
          pin_router_pkg::SEL_AUDIO:    c = '{pin_router_pkg::K_OUT, s.audio_pwm};
          pin_router_pkg::SEL2_FLASH_LED: c = '{pin_router_pkg::K_OUT, s.flash_media_led};
          pin_router_pkg::SEL_B:        c = '{pin_router_pkg::K_OUT, s.intc};
          pin_router_pkg::SEL_C:        c = '{pin_router_pkg::K_OUT, s.ring_out};
          pin_router_pkg::SEL_D:        c = '{pin_router_pkg::K_OUT, s.internal_test_multiplexer};
          pin_router_pkg::SEL_IRQ15:    c = '{pin_router_pkg::K_OUT, s.irq[pin_router_pkg::IRQ7]};
          pin_router_pkg::SEL_IRQ3,
          pin_router_pkg::SEL_IRQ4,
          pin_router_pkg::SEL_IRQ5,
          pin_router_pkg::SEL_A:        c = '{pin_router_pkg::K_OUT, s.irq[code]};
          default:                      ; // [R11] [R12] [R17]
        endcase
      end
      1, 0:
      begin
        case (code)
          pin_router_pkg::SEL_GPI:      c.kind = pin_router_pkg::K_GPI;
          pin_router_pkg::SEL_C:        c = '{pin_router_pkg::K_OUT, s.led_a_one};
          pin_router_pkg::SEL_D:        c = '{pin_router_pkg::K_OUT, s.led_a_two};
          pin_router_pkg::SEL_IRQ15:    c = '{pin_router_pkg::K_OUT, s.irq[code]};
          default:                      ; // [R13] [R17]
        endcase
        // terminal 0 adds audio and irq9-irq11
        if (idx == 0 && code == pin_router_pkg::SEL_AUDIO)
          c = '{pin_router_pkg::K_OUT, s.audio_pwm}; // [R14]
        if (idx == 0 && code >= pin_router_pkg::SEL_IRQ9 && code <= pin_router_pkg::SEL_B)
          c = '{pin_router_pkg::K_OUT, s.irq[code]}; // [R14]
      end
      default:
        c.kind = pin_router_pkg::K_NONE; // [R5] terminal 6 has no function
    endcase
    return c;
  endfunction : decode

  // terminal index feeding each general input bit
  function automatic int gp_pin(input int g);
    return (g >= 3) ? g + 1 : g;
  endfunction : gp_pin

  // ==========================================================
  // per-terminal configuration
  pin_router_pkg::pin_cfg_t cfg [NP];
  logic [3:0]               sel [NP];

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_pin
      assign sel[gi] = st_r.route[4*gi +: 4];
      assign cfg[gi] = decode(gi, sel[gi], i_src, st_r.gpo, ~st_r.general_purpose_event_out);
    end
  endgenerate

  // ==========================================================
  // bus decode
  logic        req;
  logic        hit_route;
  logic        hit_gpio;
  logic [31:0] bmask;
  logic [31:0] gpio_word;

  assign req       = i_read | i_write;
  assign hit_route = (i_address == pin_router_pkg::ROUTE_OFFSET);
  assign hit_gpio  = (i_address == pin_router_pkg::GPIO_OFFSET);
  assign bmask     = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                      {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  // one wait cycle then answer
  assign o_waitrequest = req & ~st_r.ack;

  // gpio word as read
  always_comb
  begin
    gpio_word = '0;
    gpio_word[pin_router_pkg::STS_LSB +: NG] = st_r.sts;
    gpio_word[pin_router_pkg::EN_LSB  +: NG] = st_r.en;
    gpio_word[pin_router_pkg::IN_LSB  +: NG] = st_r.gpi;
    gpio_word[pin_router_pkg::OUT_LSB +: NG] = st_r.gpo;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    logic        wr_now;
    logic [31:0] wd;
    logic [NG-1:0] chg;
    logic [NG-1:0] clr;
    wr_now = 1'b0;
    wd     = '0;
    chg    = '0;
    clr    = '0;
    st_nxt = st_r;
    st_nxt.ack = req & ~st_r.ack;
    // read data captured during the wait cycle
    st_nxt.rdata = '0;
    if (i_read && hit_route)
      st_nxt.rdata = st_r.route & pin_router_pkg::ROUTE_MASK; // [R3]
    else if (i_read && hit_gpio)
      st_nxt.rdata = gpio_word;
    wr_now = i_write & st_r.ack;
    wd     = i_writedata;
    // routing register write, top nibble dropped
    if (wr_now && hit_route)
      st_nxt.route = ((st_r.route & ~bmask) | (wd & bmask))
                     & pin_router_pkg::ROUTE_MASK; // [R1] [R3]
    // eeprom default overrides a bus write
    if (i_eeprom_load)
      st_nxt.route = i_eeprom_data & pin_router_pkg::ROUTE_MASK; // [R2] [R3]
    // gpio word write: enable, output, status clear
    if (wr_now && hit_gpio && i_byteenable[1])
      st_nxt.en = wd[pin_router_pkg::EN_LSB +: NG];
    if (wr_now && hit_gpio && i_byteenable[3])
      st_nxt.gpo = wd[pin_router_pkg::OUT_LSB +: NG];
    if (wr_now && hit_gpio && i_byteenable[0])
      clr = wd[pin_router_pkg::STS_LSB +: NG];
    // input sampling and change events, set wins over clear
    for (int g = 0; g < NG; g++)
    begin
      if (cfg[gp_pin(g)].kind == pin_router_pkg::K_GPI)
      begin
        st_nxt.gpi[g] = pin_s[gp_pin(g)];
        chg[g]        = pin_s[gp_pin(g)] ^ st_r.gpi[g]; // [R15]
      end
    end
    st_nxt.sts = (st_r.sts & ~clr) | chg; // [R15]
    st_nxt.general_purpose_event_out = |(st_nxt.sts & st_nxt.en);
    // terminal drive, registered
    st_nxt.grant = 1'b1;
    st_nxt.rx    = 1'b1;
    for (int p = 0; p < NP; p++)
    begin
      st_nxt.drv.pin_oe[p]  = (cfg[p].kind == pin_router_pkg::K_OUT); // [R18]
      st_nxt.drv.pin_out[p] = (cfg[p].kind == pin_router_pkg::K_OUT)
                              & cfg[p].level; // [R16] [R17] [R18]
      if (cfg[p].kind == pin_router_pkg::K_GRANT)
        st_nxt.grant = pin_s[p];
      if (cfg[p].kind == pin_router_pkg::K_RX)
        st_nxt.rx = pin_s[p];
    end
  end

  // ==========================================================
  // state register, global reset only
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      st_r       <= '0;
      st_r.route <= pin_router_pkg::ROUTE_RESET; // [R4]
      st_r.grant <= 1'b1;
      st_r.rx    <= 1'b1;
    end
    else if (i_ce)
      st_r <= st_nxt;
  end

  // outputs
  assign o_readdata             = st_r.rdata;
  assign o_pin_out              = st_r.drv.pin_out;
  assign o_pin_oe               = st_r.drv.pin_oe;
  assign o_pci_grant_line       = st_r.grant;
  assign o_debug_serial_receive = st_r.rx;
  assign o_gpe_active           = st_r.general_purpose_event_out;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  logic wr_now_dbg;
  assign wr_now_dbg = i_write & st_r.ack & hit_gpio;

  a_reserved_top_zero: assert property ( // [R3]
    st_r.route[31:28] == 4'h0)
    else $error("routing top bits not zero");

  a_reset_route_value: assert property ( // [R4]
    @(posedge i_core_clk) disable iff (1'b0)
    !i_rstn |=> st_r.route == pin_router_pkg::ROUTE_RESET)
    else $error("routing reset value wrong");

  a_eeprom_load_taken: assert property ( // [R2]
    i_ce && i_eeprom_load |=> st_r.route == ($past(i_eeprom_data) & pin_router_pkg::ROUTE_MASK))
    else $error("eeprom load not taken");

  a_wait_one_cycle: assert property (
    i_ce && req && o_waitrequest && hit_route |=> (!req || !o_waitrequest))
    else $error("waitrequest held too long");

  a_pin6_idle: assert property ( // [R5]
    i_ce |=> !o_pin_oe[6])
    else $error("terminal 6 driven");

  a_gpo_drives_pin: assert property ( // [R16]
    i_ce && sel[5] == pin_router_pkg::SEL_GPO
    |=> o_pin_oe[5] && o_pin_out[5] == $past(st_r.gpo[4]))
    else $error("general output not driven");

  a_gpi_undriven: assert property ( // [R18]
    i_ce && sel[4] == pin_router_pkg::SEL_GPI |=> !o_pin_oe[4])
    else $error("general input driven");

  a_reserved_idle: assert property ( // [R17]
    i_ce && sel[2] inside {4'h6, 4'h7} |=> !o_pin_oe[2])
    else $error("reserved code drives terminal");

  a_gpi_event_set: assert property ( // [R15]
    i_ce && sel[0] == pin_router_pkg::SEL_GPI && pin_s[0] != st_r.gpi[0]
    |=> st_r.sts[0] ##1 (st_r.sts[0] || $past(wr_now_dbg)))
    else $error("input change lost");

  a_pin3_irq_level: assert property ( // [R10]
    i_ce && sel[3] >= pin_router_pkg::SEL_PCI_LINE
    |=> o_pin_oe[3] && o_pin_out[3] == $past(i_src.irq[sel[3]]))
    else $error("terminal 3 irq mismatch");

  c_eeprom_load: cover property (i_ce && i_eeprom_load);
  c_route_write: cover property (i_write && st_r.ack && hit_route);
  c_gpi_event:   cover property (st_r.sts != '0 && st_r.general_purpose_event_out);
  c_status_clear: cover property (wr_now_dbg && i_byteenable[0] && st_r.sts != '0);
endmodule : multifunction_pin_router
`default_nettype wire

// ### tb/pin_board_model.sv
// board model: the level seen on each multifunction terminal
// assumes the router's out/oe pair; board drives a level where router does not
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  input  wire logic [6:0] i_pin_out,
  input  wire logic [6:0] i_pin_oe,
  input  wire logic [6:0] i_level,
  output logic      [6:0] o_pin_in
);
  // ==========================================================
  // wire resolution: router driver wins, else board level
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_level);
endmodule : pin_board_model
`default_nettype wire

// ### tb/tb_multifunction_pin_router.sv
// testbench: routing register, terminal decode, gpio event and output paths
// assumes the board model and an avalon-mm master driven from this module
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t: got %h exp %h", $time, (got), (exp)); end end
module tb_multifunction_pin_router;
  logic                  i_core_clk;
  logic                  i_rstn;
  logic                  ce = 1'b1;
  logic [7:0]            i_address;
  logic                  i_read;
  logic                  i_write;
  logic [3:0]            i_byteenable;
  logic [31:0]           i_writedata;
  logic [31:0]           o_readdata;
  logic                  o_waitrequest;
  logic                  i_eeprom_load;
  logic [31:0]           i_eeprom_data;
  pin_router_pkg::src_t  src;
  logic                  o_pci_grant_line;
  logic                  o_debug_serial_receive;
  logic                  o_gpe_active;
  logic [6:0]            pin_in;
  logic [6:0]            pin_out;
  logic [6:0]            pin_oe;
  logic [6:0]            lvl;
  logic [31:0]           rnd;
  int                    n_fail;
  int                    check_count;
  int                    cyc;

  multifunction_pin_router i_multifunction_pin_router (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(ce), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
    .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_eeprom_load(i_eeprom_load), .i_eeprom_data(i_eeprom_data), .i_src(src),
    .o_pci_grant_line(o_pci_grant_line), .o_debug_serial_receive(o_debug_serial_receive),
    .o_gpe_active(o_gpe_active), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe));

  pin_board_model i_pin_board_model (
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_level(lvl), .o_pin_in(pin_in));

  // ==========================================================
  // clock and run limit
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected {oe, out} of terminals 0 to 5 with gpo and gpe idle
  function automatic logic [1:0] exp_drive(input int p, input logic [3:0] c,
                                           input pin_router_pkg::src_t s);
    logic [1:0] r;
    r = 2'b00;
    if (p == 3)
      r = (c == 4'h0) ? 2'b00 : {1'b1, (c == 4'h1) ? s.serirq : s.irq[c]};
    else if (p == 2 || p == 4)
    begin
      case (c)
        4'h1:       r = 2'b10;
        4'h2:       r = (p == 2) ? {1'b1, s.pci_req} : 2'b00;
        4'h3, 4'h4: r = {1'b1, s.irq[c]};
        4'h5:       r = {1'b1, (p == 2) ? s.irq[5] : s.dbg_tx};
        4'h8:       r = {1'b1, s.audio_pwm};
        4'h9:       r = {1'b1, (p == 2) ? s.flash_media_led : s.irq[9]};
        4'ha:       r = {1'b1, (p == 2) ? s.irq[10] : s.intd};
        4'hb:       r = {1'b1, (p == 2) ? s.intc : s.flash_media_led};
        4'hc:       r = {1'b1, s.ring_out};
        4'hd:       r = {1'b1, (p == 2) ? s.internal_test_multiplexer : s.skt_led};
        4'he:       r = 2'b11;
        4'hf:       r = {1'b1, (p == 2) ? s.irq[7] : s.irq[15]};
        default:    r = 2'b00;
      endcase
    end
    else
    begin
      case (c)
        4'h1:       r = (p == 5) ? 2'b10 : 2'b00;
        4'h3, 4'h5: r = (p == 5) ? {1'b1, s.irq[c]} : 2'b00;
        4'h8:       r = {1'b1, s.audio_pwm};
        4'h9, 4'hf: r = {1'b1, s.irq[c]};
        4'ha:       r = {1'b1, (p == 5) ? s.flash_media_led : s.irq[10]};
        4'hb:       r = {1'b1, (p == 5) ? s.link_led : s.irq[11]};
        4'hc:       r = {1'b1, s.led_a_one};
        4'hd:       r = {1'b1, (p == 5) ? s.skt_led : s.led_a_two};
        4'he:       r = 2'b11;
        default:    r = 2'b00;
      endcase
      if (p == 1 && c < 4'hc) r = 2'b00;
    end
    return r;
  endfunction : exp_drive

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    i_write      <= w;
    i_read       <= ~w;
    i_address    <= a;
    i_writedata  <= d;
    i_byteenable <= be;
    do @(posedge i_core_clk); while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_write <= 1'b0;
    i_read  <= 1'b0;
    @(posedge i_core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    `CHK(q, e)
  endtask : rd

  // short global reset, so each routing set-up is a fresh power-on
  task automatic pon_reset;
    i_rstn <= 1'b0;
    @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(posedge i_core_clk);
  endtask : pon_reset

  task finish_test;
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ==========================================================
  // main sequence
  initial
  begin
    n_fail = 0; check_count = 0; cyc = 0;
    i_rstn = 1'b0; i_address = 8'h00; i_read = 1'b0; i_write = 1'b0;
    i_byteenable = 4'h0; i_writedata = 32'h0000_0000; i_eeprom_load = 1'b0;
    i_eeprom_data = 32'h0000_0000; lvl = 7'h00;
    rnd = 32'h86b3_74f9;
    src = pin_router_pkg::src_t'(rnd[28:0]);
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    `CHK({pin_oe[3], pin_out[3]}, {1'b1, src.serirq})
    `CHK({o_pci_grant_line, o_debug_serial_receive, o_gpe_active}, 3'b110)
    rd(pin_router_pkg::ROUTE_OFFSET, pin_router_pkg::ROUTE_RESET);
    // reserved top nibble and byte lanes
    wr(pin_router_pkg::ROUTE_OFFSET, 32'hffff_ffff, 4'hf);
    rd(pin_router_pkg::ROUTE_OFFSET, 32'h0fff_ffff);
    wr(pin_router_pkg::ROUTE_OFFSET, 32'h0000_0000, 4'b0010);
    rd(pin_router_pkg::ROUTE_OFFSET, 32'h0fff_00ff);
    // unmapped place: read zero, write has no effect
    wr(8'h40, 32'h0000_0000, 4'hf);
    rd(8'h40, 32'h0000_0000);
    rd(pin_router_pkg::ROUTE_OFFSET, 32'h0fff_00ff);
    // default from the serial loader
    rnd = lfsr(rnd);
    i_eeprom_data <= rnd;
    i_eeprom_load <= 1'b1;
    @(posedge i_core_clk);
    i_eeprom_load <= 1'b0;
    @(posedge i_core_clk);
    rd(pin_router_pkg::ROUTE_OFFSET, rnd & pin_router_pkg::ROUTE_MASK);
    // every code on terminals 0 to 5 with random sources and board levels
    for (int p = 0; p < 6; p++)
    begin
      for (int c = 0; c < 16; c++)
      begin
        rnd = lfsr(rnd);
        src <= pin_router_pkg::src_t'(rnd[28:0]);
        lvl <= rnd[31:25];
        pon_reset();
        wr(pin_router_pkg::ROUTE_OFFSET, {28'h0, 4'(c)} << (4 * p), 4'hf);
        repeat (4) @(posedge i_core_clk);
        `CHK({pin_oe[p], pin_out[p]}, exp_drive(p, 4'(c), src))
        `CHK(o_pci_grant_line, (p == 5 && c == 2) ? lvl[5] : 1'b1)
        `CHK(o_debug_serial_receive, (p == 5 && c == 4) ? lvl[5] : 1'b1)
      end
    end
    // input change flag, enable and clear
    pon_reset();
    lvl <= 7'h00;
    repeat (6) @(posedge i_core_clk);
    wr(pin_router_pkg::GPIO_OFFSET, 32'h0000_001f, 4'b0001);
    rd(pin_router_pkg::GPIO_OFFSET, 32'h0000_0000);
    lvl <= 7'h02;
    repeat (5) @(posedge i_core_clk);
    rd(pin_router_pkg::GPIO_OFFSET, 32'h0002_0002);
    wr(pin_router_pkg::GPIO_OFFSET, 32'h0000_0200, 4'b0010);
    repeat (2) @(posedge i_core_clk);
    `CHK(o_gpe_active, 1'b1)
    wr(pin_router_pkg::GPIO_OFFSET, 32'h0000_0002, 4'b0001);
    repeat (2) @(posedge i_core_clk);
    `CHK(o_gpe_active, 1'b0)
    // general output on terminal 5
    pon_reset();
    wr(pin_router_pkg::ROUTE_OFFSET, 32'h0010_1000, 4'hf);
    wr(pin_router_pkg::GPIO_OFFSET, 32'h1000_0000, 4'b1000);
    repeat (2) @(posedge i_core_clk);
    `CHK({pin_oe[5], pin_out[5]}, 2'b11)
    wr(pin_router_pkg::GPIO_OFFSET, 32'h0000_0000, 4'b1000);
    repeat (2) @(posedge i_core_clk);
    `CHK({pin_oe[5], pin_out[5]}, 2'b10)
    // frozen clock enable: a loader pulse must not land
    ce            <= 1'b0;
    i_eeprom_data <= 32'h0000_0000;
    i_eeprom_load <= 1'b1;
    @(posedge i_core_clk);
    i_eeprom_load <= 1'b0;
    ce            <= 1'b1;
    @(posedge i_core_clk);
    rd(pin_router_pkg::ROUTE_OFFSET, 32'h0010_1000);
    // last global reset, held for two cycles
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(posedge i_core_clk);
    rd(pin_router_pkg::ROUTE_OFFSET, pin_router_pkg::ROUTE_RESET);
    finish_test();
  end
endmodule : tb_multifunction_pin_router
`default_nettype wire
